// ==== core/rmrs_pkg.sv ====
// Shared constants, types and command codes of the relay matrix route and scan block.
package rmrs_pkg;
   localparam int NUM_CARDS = 2;
   localparam int XP_PER_CARD = 256;
   localparam int LOCAL_W = 8;
   localparam int XP_TOTAL = NUM_CARDS * XP_PER_CARD;
   localparam int IDX_W = 9;
   localparam int CODE_W = 24;
   localparam int DATA_W = 16;
   localparam logic [7:0] QRY_MAX = 8'h80;
   localparam int SCAN_DEPTH = 16;
   localparam int SPTR_W = 4;
   localparam int SLEN_W = 5;
   localparam int TRIG_LINES = 8;
   localparam int LINE_W = 3;
   localparam int EVT_SCAN_DONE_BIT = 8;
   localparam logic [3:0] PULSE_CYC = 4'h4;
   localparam logic [6:0] CARD_MIN = 7'h01;
   localparam logic [6:0] ROWS_16X16 = 7'h10;
   localparam logic [6:0] COLS_16X16 = 7'h10;
   localparam logic [6:0] ROWS_4X64 = 7'h04;
   localparam logic [6:0] COLS_4X64 = 7'h40;
   localparam logic [6:0] ROWS_8X32 = 7'h08;
   localparam logic [6:0] COLS_8X32 = 7'h20;

   typedef enum logic [1:0] {RMRS_V16X16, RMRS_V4X64, RMRS_V8X32} rmrs_variant_t;

   // Matrix variant fitted in each card slot, slot 0 holding card 01.
   localparam rmrs_variant_t CARD_VARIANT [NUM_CARDS] = '{RMRS_V16X16, RMRS_V4X64};

   typedef enum logic [3:0] {
      RMRS_OP_CLOSE, RMRS_OP_OPEN, RMRS_OP_QRY_CLOSED, RMRS_OP_QRY_OPEN, RMRS_OP_SCAN_DEF,
      RMRS_OP_LAUNCH, RMRS_OP_ABORT, RMRS_OP_RESET, RMRS_OP_CONT, RMRS_OP_TRIG_SET,
      RMRS_OP_TRIG_QRY, RMRS_OP_EVENT_READ
   } rmrs_op_t;
endpackage

// ==== core/rmrs_code_decode.sv ====
// Decodes one six-digit card-row-column code into a flat crosspoint index and checks it.
module rmrs_code_decode (
   input wire logic [rmrs_pkg::CODE_W-1:0] code,
   output logic valid,
   output logic [rmrs_pkg::IDX_W-1:0] idx
);
   function automatic logic [6:0] rmrs_bcd2(input logic [7:0] d);
      return 7'(d[7:4]) * 7'h0A + 7'(d[3:0]);
   endfunction

   function automatic logic rmrs_digits_ok(input logic [7:0] d);
      return (d[7:4] <= 4'h9) && (d[3:0] <= 4'h9);
   endfunction

   logic [6:0] card;
   logic [6:0] row;
   logic [6:0] col;
   logic card_ok;
   logic fits;
   logic [rmrs_pkg::LOCAL_W-1:0] local_idx;
   rmrs_pkg::rmrs_variant_t variant;

   always_comb begin
      card = rmrs_bcd2(code[23:16]);
      row = rmrs_bcd2(code[15:8]);
      col = rmrs_bcd2(code[7:0]);
      card_ok = 1'b0;
      variant = rmrs_pkg::RMRS_V16X16;
      for (int i = 0; i < rmrs_pkg::NUM_CARDS; i++) begin
         if (card == 7'(i + 1)) begin
            card_ok = 1'b1;
            variant = rmrs_pkg::CARD_VARIANT[i];
         end
      end
      unique case (variant)
         rmrs_pkg::RMRS_V16X16: begin
            fits = (row < rmrs_pkg::ROWS_16X16) && (col < rmrs_pkg::COLS_16X16);
            local_idx = {row[3:0], col[3:0]};
         end
         rmrs_pkg::RMRS_V4X64: begin
            fits = (row < rmrs_pkg::ROWS_4X64) && (col < rmrs_pkg::COLS_4X64);
            local_idx = {row[1:0], col[5:0]};
         end
         default: begin
            fits = (row < rmrs_pkg::ROWS_8X32) && (col < rmrs_pkg::COLS_8X32);
            local_idx = {row[2:0], col[4:0]};
         end
      endcase
      valid = rmrs_digits_ok(code[23:16]) && rmrs_digits_ok(code[15:8]) && rmrs_digits_ok(code[7:0])
              && card_ok && fits && (card >= rmrs_pkg::CARD_MIN);
      idx = rmrs_pkg::IDX_W'((int'(card) - 1) * rmrs_pkg::XP_PER_CARD + int'(local_idx));
   end
endmodule

// ==== core/rmrs_core.sv ====
// Relay matrix route, query and trigger-driven scan command engine.
// Functional notes
// - Trigger line query answers its enable state.
// - Close command closes every listed crosspoint.
// - Row and column limits follow card variant.
// - Lists mix single codes and ranges.
// - Entry order free; no closing order promised.
// - Reset command opens every crosspoint.
// - Closed query answers one per closed point.
// - Queries read commanded state, not contacts.
// - At most 128 crosspoints per query.
// - Open command opens every listed crosspoint.
// - Open query answers one per open point.
// - Scan list entries validated; error if bad.
// - Launch closes first scan list entry.
// - Each advance trigger steps to next entry.
// - Single scan ends with last entry opened.
// - Enabled line pulses low after scan close.
// - Enabling a line disables the previous one.
// - Continuous scan wraps to first entry.
// - Cycle end sets bit 8; read clears.
module rmrs_core (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [3:0] cmd_op,
   input wire logic [rmrs_pkg::CODE_W-1:0] cmd_lo,
   input wire logic [rmrs_pkg::CODE_W-1:0] cmd_hi,
   input wire logic cmd_range,
   input wire logic cmd_last,
   input wire logic [rmrs_pkg::LINE_W-1:0] cmd_line,
   input wire logic cmd_mode,
   input wire logic adv_trig,
   output logic resp_valid,
   output logic [rmrs_pkg::DATA_W-1:0] resp_data,
   output logic err_pulse,
   output logic scan_active,
   output logic [rmrs_pkg::XP_TOTAL-1:0] xp_state,
   output logic [rmrs_pkg::TRIG_LINES-1:0] backplane_trigger_line_n
);
   typedef enum logic {RMRS_IDLE, RMRS_WALK} rmrs_state_t;

   rmrs_state_t state_ff, nxt_state;
   rmrs_pkg::rmrs_op_t op_ff, nxt_op;
   logic [rmrs_pkg::IDX_W-1:0] cur_ff, nxt_cur, end_ff, nxt_end;
   logic last_ff, nxt_last, in_list_ff, nxt_in_list;
   logic [7:0] qcnt_ff, nxt_qcnt;
   logic [rmrs_pkg::XP_TOTAL-1:0] xp_ff, nxt_xp;
   logic [rmrs_pkg::IDX_W-1:0] slist_ff [rmrs_pkg::SCAN_DEPTH];
   logic [rmrs_pkg::IDX_W-1:0] nxt_slist [rmrs_pkg::SCAN_DEPTH];
   logic [rmrs_pkg::SLEN_W-1:0] slen_ff, nxt_slen;
   logic sbad_ff, nxt_sbad, sok_ff, nxt_sok;
   logic run_ff, nxt_run, cont_ff, nxt_cont, evt_ff, nxt_evt;
   logic [rmrs_pkg::SPTR_W-1:0] sptr_ff, nxt_sptr;
   logic ten_ff, nxt_ten;
   logic [rmrs_pkg::LINE_W-1:0] tsel_ff, nxt_tsel;
   logic rv_ff, nxt_rv, err_ff, nxt_err, fire_ff, nxt_fire;
   logic [rmrs_pkg::DATA_W-1:0] rd_ff, nxt_rd;
   logic [3:0] pcnt_ff, nxt_pcnt;
   logic [rmrs_pkg::TRIG_LINES-1:0] tl_n_ff, nxt_tl_n;
   logic lo_ok, hi_ok, entry_ok, accept, list_end, walk_done, stop;
   logic [rmrs_pkg::IDX_W-1:0] lo_idx, hi_idx, end_idx;
   rmrs_pkg::rmrs_op_t op_in;

   rmrs_code_decode u_lo (.code(cmd_lo), .valid(lo_ok), .idx(lo_idx));
   rmrs_code_decode u_hi (.code(cmd_hi), .valid(hi_ok), .idx(hi_idx));

   assign cmd_ready = (state_ff == RMRS_IDLE);
   assign resp_valid = rv_ff;
   assign resp_data = rd_ff;
   assign err_pulse = err_ff;
   assign scan_active = run_ff;
   assign xp_state = xp_ff;
   assign backplane_trigger_line_n = tl_n_ff;

   always_comb begin
      op_in = rmrs_pkg::rmrs_op_t'(cmd_op);
      accept = cmd_valid && (state_ff == RMRS_IDLE);
      end_idx = cmd_range ? hi_idx : lo_idx;
      entry_ok = lo_ok && (!cmd_range || (hi_ok && hi_idx[rmrs_pkg::IDX_W-1:rmrs_pkg::LOCAL_W]
                 == lo_idx[rmrs_pkg::IDX_W-1:rmrs_pkg::LOCAL_W] && lo_idx <= hi_idx));
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_cur = cur_ff;
      nxt_end = end_ff;
      nxt_last = last_ff;
      nxt_in_list = in_list_ff;
      nxt_qcnt = qcnt_ff;
      nxt_xp = xp_ff;
      nxt_slist = slist_ff;
      nxt_slen = slen_ff;
      nxt_sbad = sbad_ff;
      nxt_sok = sok_ff;
      nxt_run = run_ff;
      nxt_cont = cont_ff;
      nxt_evt = evt_ff;
      nxt_sptr = sptr_ff;
      nxt_ten = ten_ff;
      nxt_tsel = tsel_ff;
      nxt_rv = 1'b0;
      nxt_rd = '0;
      nxt_err = 1'b0;
      nxt_fire = 1'b0;
      list_end = 1'b0;
      walk_done = 1'b0;
      stop = 1'b0;
      if (accept) begin
         unique case (op_in)
            rmrs_pkg::RMRS_OP_CLOSE, rmrs_pkg::RMRS_OP_OPEN, rmrs_pkg::RMRS_OP_QRY_CLOSED,
            rmrs_pkg::RMRS_OP_QRY_OPEN, rmrs_pkg::RMRS_OP_SCAN_DEF: begin
               if (op_in == rmrs_pkg::RMRS_OP_SCAN_DEF) begin
                  stop = 1'b1;
                  nxt_run = 1'b0;
                  if (!in_list_ff) begin
                     nxt_slen = '0;
                     nxt_sbad = 1'b0;
                     nxt_sok = 1'b0;
                  end
               end
               nxt_in_list = 1'b1;
               nxt_op = op_in;
               nxt_last = cmd_last;
               if (entry_ok) begin
                  nxt_state = RMRS_WALK;
                  nxt_cur = lo_idx;
                  nxt_end = end_idx;
               end else begin
                  nxt_err = 1'b1;
                  nxt_sbad = 1'b1;
                  list_end = cmd_last;
               end
            end
            rmrs_pkg::RMRS_OP_LAUNCH: begin
               stop = 1'b1;
               if (sok_ff) begin
                  if (run_ff) begin
                     nxt_xp[slist_ff[sptr_ff]] = 1'b0;
                  end
                  nxt_xp[slist_ff[0]] = 1'b1;
                  nxt_sptr = '0;
                  nxt_run = 1'b1;
                  nxt_fire = 1'b1;
               end else begin
                  nxt_err = 1'b1;
               end
            end
            rmrs_pkg::RMRS_OP_ABORT: begin
               stop = 1'b1;
               nxt_run = 1'b0;
               nxt_evt = 1'b0;
            end
            rmrs_pkg::RMRS_OP_RESET: begin
               stop = 1'b1;
               nxt_xp = '0;
               nxt_run = 1'b0;
               nxt_cont = 1'b0;
               nxt_evt = 1'b0;
               nxt_ten = 1'b0;
            end
            rmrs_pkg::RMRS_OP_CONT: nxt_cont = cmd_mode;
            rmrs_pkg::RMRS_OP_TRIG_SET: begin
               if (cmd_mode) begin
                  nxt_ten = 1'b1;
                  nxt_tsel = cmd_line;
               end else if (cmd_line == tsel_ff) begin
                  nxt_ten = 1'b0;
               end
            end
            rmrs_pkg::RMRS_OP_TRIG_QRY: begin
               nxt_rv = 1'b1;
               nxt_rd[0] = ten_ff && (tsel_ff == cmd_line);
            end
            rmrs_pkg::RMRS_OP_EVENT_READ: begin
               nxt_rv = 1'b1;
               nxt_rd[rmrs_pkg::EVT_SCAN_DONE_BIT] = evt_ff;
               nxt_evt = 1'b0;
            end
            default: nxt_err = 1'b1;
         endcase
      end
      if (state_ff == RMRS_WALK) begin
         unique case (op_ff)
            rmrs_pkg::RMRS_OP_CLOSE: nxt_xp[cur_ff] = 1'b1;
            rmrs_pkg::RMRS_OP_OPEN: nxt_xp[cur_ff] = 1'b0;
            rmrs_pkg::RMRS_OP_SCAN_DEF: begin
               if (slen_ff < rmrs_pkg::SLEN_W'(rmrs_pkg::SCAN_DEPTH)) begin
                  nxt_slist[slen_ff[rmrs_pkg::SPTR_W-1:0]] = cur_ff;
                  nxt_slen = slen_ff + 1'b1;
               end else begin
                  nxt_sbad = 1'b1;
               end
            end
            default: begin
               if (qcnt_ff == rmrs_pkg::QRY_MAX) begin
                  nxt_err = 1'b1;
               end else begin
                  nxt_qcnt = qcnt_ff + 8'h01;
                  nxt_rv = 1'b1;
                  nxt_rd[0] = (op_ff == rmrs_pkg::RMRS_OP_QRY_CLOSED) ? xp_ff[cur_ff] : !xp_ff[cur_ff];
               end
            end
         endcase
         if (cur_ff == end_ff) begin
            walk_done = 1'b1;
            nxt_state = RMRS_IDLE;
            list_end = last_ff;
         end else begin
            nxt_cur = cur_ff + 1'b1;
         end
      end
      if (list_end) begin
         nxt_in_list = 1'b0;
         nxt_qcnt = '0;
         if (op_in == rmrs_pkg::RMRS_OP_SCAN_DEF && !walk_done || walk_done && op_ff == rmrs_pkg::RMRS_OP_SCAN_DEF) begin
            nxt_sok = !nxt_sbad && (nxt_slen != '0);
            nxt_err = nxt_err || nxt_sbad;
         end
      end
      if (run_ff && adv_trig && !stop) begin
         nxt_xp[slist_ff[sptr_ff]] = 1'b0;
         if (SLEN_W_EXT(sptr_ff) + 1'b1 == slen_ff) begin
            nxt_evt = 1'b1;
            if (cont_ff) begin
               nxt_sptr = '0;
               nxt_xp[slist_ff[0]] = 1'b1;
               nxt_fire = 1'b1;
            end else begin
               nxt_run = 1'b0;
            end
         end else begin
            nxt_sptr = sptr_ff + 1'b1;
            nxt_xp[slist_ff[sptr_ff + 1'b1]] = 1'b1;
            nxt_fire = 1'b1;
         end
      end
   end

   function automatic logic [rmrs_pkg::SLEN_W-1:0] SLEN_W_EXT(input logic [rmrs_pkg::SPTR_W-1:0] p);
      return {1'b0, p};
   endfunction

   always_comb begin
      nxt_pcnt = pcnt_ff;
      if (fire_ff && ten_ff) begin
         nxt_pcnt = rmrs_pkg::PULSE_CYC;
      end else if (pcnt_ff != 4'h0) begin
         nxt_pcnt = pcnt_ff - 4'h1;
      end
      nxt_tl_n = '1;
      if (nxt_pcnt != 4'h0 && ten_ff) begin
         nxt_tl_n[tsel_ff] = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= RMRS_IDLE;
         op_ff <= rmrs_pkg::RMRS_OP_CLOSE;
         cur_ff <= '0;
         end_ff <= '0;
         last_ff <= 1'b0;
         in_list_ff <= 1'b0;
         qcnt_ff <= '0;
         xp_ff <= '0;
         for (int i = 0; i < rmrs_pkg::SCAN_DEPTH; i++) begin
            slist_ff[i] <= '0;
         end
         slen_ff <= '0;
         sbad_ff <= 1'b0;
         sok_ff <= 1'b0;
         run_ff <= 1'b0;
         cont_ff <= 1'b0;
         evt_ff <= 1'b0;
         sptr_ff <= '0;
         ten_ff <= 1'b0;
         tsel_ff <= '0;
         rv_ff <= 1'b0;
         rd_ff <= '0;
         err_ff <= 1'b0;
         fire_ff <= 1'b0;
         pcnt_ff <= 4'h0;
         tl_n_ff <= '1;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         cur_ff <= nxt_cur;
         end_ff <= nxt_end;
         last_ff <= nxt_last;
         in_list_ff <= nxt_in_list;
         qcnt_ff <= nxt_qcnt;
         xp_ff <= nxt_xp;
         slist_ff <= nxt_slist;
         slen_ff <= nxt_slen;
         sbad_ff <= nxt_sbad;
         sok_ff <= nxt_sok;
         run_ff <= nxt_run;
         cont_ff <= nxt_cont;
         evt_ff <= nxt_evt;
         sptr_ff <= nxt_sptr;
         ten_ff <= nxt_ten;
         tsel_ff <= nxt_tsel;
         rv_ff <= nxt_rv;
         rd_ff <= nxt_rd;
         err_ff <= nxt_err;
         fire_ff <= nxt_fire;
         pcnt_ff <= nxt_pcnt;
         tl_n_ff <= nxt_tl_n;
      end
   end
endmodule

// ==== testbench/rmrs_core_checker.sv ====
// Port checker of the relay matrix route and scan engine.
module rmrs_core_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [3:0] cmd_op,
   input wire logic cmd_range,
   input wire logic adv_trig,
   input wire logic resp_valid,
   input wire logic err_pulse,
   input wire logic scan_active,
   input wire logic [rmrs_pkg::XP_TOTAL-1:0] xp_state,
   input wire logic [rmrs_pkg::TRIG_LINES-1:0] backplane_trigger_line_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire tk = cmd_valid && cmd_ready;
   wire idle = &backplane_trigger_line_n;
   AST_TRIG_PULSE: assert property ($fell(idle) |-> (!idle)[*4] ##1 idle)
      else $error("Trigger pulse width wrong.");
   AST_ONE_LINE: assert property ($countones(~backplane_trigger_line_n) <= 1)
      else $error("Two trigger lines active.");
   AST_LAUNCH: assert property (tk && cmd_op == 4'h5 |=> err_pulse || (scan_active && xp_state != '0))
      else $error("Launch closed nothing.");
   AST_ADVANCE: assert property (adv_trig && scan_active && !tk |=>
      $countones(xp_state) <= $countones($past(xp_state))) else $error("Advance left two entries closed.");
   AST_RESET_CMD: assert property (tk && cmd_op == 4'h7 |-> ##[1:3] xp_state == '0)
      else $error("Reset command left a crosspoint closed.");
   AST_TRIG_QRY: assert property (tk && cmd_op == 4'hA |=> resp_valid)
      else $error("Trigger query not answered.");
   AST_OPEN_CMD: assert property (tk && cmd_op == 4'h1 && !scan_active |->
      ##2 (xp_state & ~$past(xp_state, 2)) == '0) else $error("Open command closed a crosspoint.");
   AST_QRY: assert property (tk && (cmd_op == 4'h2 || cmd_op == 4'h3) && !cmd_range |->
      ##[1:2] (resp_valid || err_pulse)) else $error("State query not answered.");
   AST_CLOSE_WALK: assert property (tk && cmd_op == 4'h0 && !cmd_range |=>
      err_pulse or (!cmd_ready ##1 cmd_ready)) else $error("Single close entry walk length wrong.");
   CVR_LAUNCH: cover property (tk && cmd_op == 4'h5);
   CVR_ADV: cover property (adv_trig && scan_active);
   CVR_ERR: cover property (err_pulse);
endmodule
bind rmrs_core rmrs_core_checker chk_u (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .cmd_op(cmd_op), .cmd_range(cmd_range), .adv_trig(adv_trig), .resp_valid(resp_valid), .err_pulse(err_pulse),
   .scan_active(scan_active), .xp_state(xp_state), .backplane_trigger_line_n(backplane_trigger_line_n));

// ==== testbench/rmrs_host_model.sv ====
// Host model that offers command entries to the engine.
module rmrs_host_model (
   input wire logic clk,
   input wire logic cmd_ready,
   output logic cmd_valid,
   output logic [3:0] cmd_op,
   output logic [rmrs_pkg::CODE_W-1:0] cmd_lo,
   output logic [rmrs_pkg::CODE_W-1:0] cmd_hi,
   output logic cmd_range,
   output logic cmd_last,
   output logic [rmrs_pkg::LINE_W-1:0] cmd_line,
   output logic cmd_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {cmd_valid, cmd_op, cmd_lo, cmd_hi, cmd_range, cmd_last, cmd_line, cmd_mode} = '0;
   end
   task automatic send(input logic [3:0] op, input logic [23:0] lo, hi, input logic rng, last,
                       input logic [2:0] line = 3'h0, input logic mode = 1'b0);
      if (!cmd_valid) begin
         @(posedge clk);
         #1;
      end
      cmd_op = op;
      cmd_lo = lo;
      cmd_hi = rng ? hi : ~lo;
      cmd_range = rng;
      cmd_last = last;
      cmd_line = line;
      cmd_mode = mode;
      cmd_valid = 1'b1;
      do @(negedge clk); while (cmd_ready !== 1'b1);
      @(posedge clk);
      #1;
      if (last) begin
         cmd_valid = 1'b0;
         {cmd_lo, cmd_hi} = ~{cmd_lo, cmd_hi};
      end
   endtask
endmodule

// ==== testbench/relay_matrix_route_scan_tb.sv ====
// Self-checking bench of the relay matrix route and scan engine.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module relay_matrix_route_scan_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic adv_trig = 1'b0;
   logic cmd_valid, cmd_ready, cmd_range, cmd_last, cmd_mode, resp_valid, err_pulse, scan_active;
   logic [3:0] cmd_op;
   logic [23:0] cmd_lo, cmd_hi, c;
   logic [2:0] cmd_line;
   logic [15:0] resp_data;
   logic [511:0] xp_state, exp_xp;
   logic [7:0] backplane_trigger_line_n;
   logic [15:0] rq[$];
   int fails = 0, samples_checked = 0, errs = 0, lows = 0, cyc = 0, k;
   always #20 clk = ~clk;
   rmrs_host_model host_u (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_lo(cmd_lo),
      .cmd_hi(cmd_hi), .cmd_range(cmd_range), .cmd_last(cmd_last), .cmd_line(cmd_line), .cmd_mode(cmd_mode));
   rmrs_core dut_u (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_lo(cmd_lo), .cmd_hi(cmd_hi), .cmd_range(cmd_range), .cmd_last(cmd_last), .cmd_line(cmd_line),
      .cmd_mode(cmd_mode), .adv_trig(adv_trig), .resp_valid(resp_valid), .resp_data(resp_data),
      .err_pulse(err_pulse), .scan_active(scan_active), .xp_state(xp_state),
      .backplane_trigger_line_n(backplane_trigger_line_n));
   always @(posedge clk) begin
      cyc++;
      if (resp_valid === 1'b1) rq.push_back(resp_data);
      if (err_pulse === 1'b1) errs++;
      if (backplane_trigger_line_n[2] === 1'b0) lows++;
      if (cyc == 30000) begin
         fails++;
         end_sim();
      end
   end
   function automatic logic [23:0] bcd(int cd, int r, int cl);
      return {4'(cd / 10), 4'(cd % 10), 4'(r / 10), 4'(r % 10), 4'(cl / 10), 4'(cl % 10)};
   endfunction
   function automatic int xidx(logic [23:0] v);
      int d[6];
      int cd, r, cl;
      for (int i = 0; i < 6; i++) begin
         if (v[23 - 4 * i -: 4] > 4'h9) return -1;
         d[i] = int'(v[23 - 4 * i -: 4]);
      end
      cd = d[0] * 10 + d[1];
      r = d[2] * 10 + d[3];
      cl = d[4] * 10 + d[5];
      if (cd == 1 && r < 16 && cl < 16) return r * 16 + cl;
      if (cd == 2 && r < 4 && cl < 64) return 256 + r * 64 + cl;
      return -1;
   endfunction
   function automatic logic [23:0] rnd();
      int cd;
      cd = $urandom_range(2, 1);
      return bcd(cd, $urandom_range(cd == 1 ? 15 : 3), $urandom_range(cd == 1 ? 15 : 63));
   endfunction
   task automatic wt(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic act(logic [3:0] op, logic [23:0] lo, logic [23:0] hi, logic rng, logic last);
      int a, b;
      a = xidx(lo);
      b = rng ? xidx(hi) : a;
      host_u.send(op, lo, hi, rng, last);
      if (a >= 0 && b >= a && (a < 256) == (b < 256)) begin
         for (int i = a; i <= b; i++) exp_xp[i] = !op[0];
      end
   endtask
   task automatic qry(logic [3:0] op, logic [23:0] lo, logic [23:0] hi, logic rng, int n);
      int a;
      a = xidx(lo);
      rq.delete();
      host_u.send(op, lo, hi, rng, 1'b1);
      wt(n + 8);
      `CHK(rq.size(), n)
      for (int i = 0; i < rq.size(); i++) `CHK(rq[i][0], exp_xp[a + i] ^ (op == 4'h3))
   endtask
   task automatic evt(logic e);
      rq.delete();
      host_u.send(4'hB, '0, '0, 1'b0, 1'b1);
      wt(2);
      `CHK(rq[0][8], e)
   endtask
   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   logic [23:0] bad[7] = '{24'h000000, 24'h031000, 24'h011600, 24'h010016, 24'h020400, 24'h020064, 24'h01A000};
   int pts[4] = '{35, 383, 384, 0};
   initial begin
      void'($urandom(50936));
      exp_xp = '0;
      repeat (20) @(posedge clk);
      #1;
      `CHK(xp_state, exp_xp)
      `CHK(backplane_trigger_line_n, 8'hFF)
      rst_n = 1'b1;
      for (int l = 0; l < 8; l++) begin
         for (int e = 0; e < 3; e++) begin
            c = rnd();
            act(4'(l % 3 == 2), c, '0, 1'b0, e == 2);
         end
         wt(3);
         `CHK(xp_state, exp_xp)
         qry(4'h2 + 4'(l % 2), c, '0, 1'b0, 1);
      end
      act(4'h0, 24'h010100, 24'h010103, 1'b1, 1'b0);
      act(4'h0, 24'h020162, 24'h020201, 1'b1, 1'b0);
      act(4'h0, 24'h010215, '0, 1'b0, 1'b1);
      wt(3);
      `CHK(xp_state, exp_xp)
      k = errs;
      foreach (bad[i]) act(4'h0, bad[i], '0, 1'b0, 1'b1);
      act(4'h0, 24'h010005, 24'h010001, 1'b1, 1'b1);
      act(4'h1, 24'h010000, 24'h020000, 1'b1, 1'b1);
      host_u.send(4'hC, '0, '0, 1'b0, 1'b1);
      wt(3);
      `CHK(errs - k, 10)
      `CHK(xp_state, exp_xp)
      qry(4'h2, 24'h010000, 24'h010015, 1'b1, 16);
      qry(4'h3, 24'h020048, 24'h020063, 1'b1, 16);
      host_u.send(4'h7, '0, '0, 1'b0, 1'b1);
      exp_xp = '0;
      wt(3);
      `CHK(xp_state, exp_xp)
      k = errs;
      qry(4'h2, 24'h010000, 24'h010801, 1'b1, 128);
      `CHK(errs - k, 2)
      host_u.send(4'h9, '0, '0, 1'b0, 1'b1, 3'h5, 1'b1);
      host_u.send(4'h9, '0, '0, 1'b0, 1'b1, 3'h2, 1'b1);
      rq.delete();
      for (int i = 0; i < 8; i++) host_u.send(4'hA, '0, '0, 1'b0, 1'b1, 3'(i));
      wt(4);
      `CHK(rq.size(), 8)
      for (int i = 0; i < 8; i++) `CHK(rq[i][0], i == 2)
      host_u.send(4'h4, 24'h010203, '0, 1'b0, 1'b0);
      host_u.send(4'h4, 24'h020163, 24'h020200, 1'b1, 1'b0);
      host_u.send(4'h4, 24'h010000, '0, 1'b0, 1'b1);
      for (int p = 0; p < 2; p++) begin
         host_u.send(4'h8, '0, '0, 1'b0, 1'b1, 3'h0, p[0]);
         lows = 0;
         host_u.send(4'h5, '0, '0, 1'b0, 1'b1);
         for (int j = 0; j <= 4; j++) begin
            wt(8);
            exp_xp = '0;
            if (j < 4 || p == 1) exp_xp[pts[j % 4]] = 1'b1;
            `CHK(xp_state, exp_xp)
            if (j < 4) begin
               adv_trig = 1'b1;
               @(posedge clk);
               #1;
               adv_trig = 1'b0;
            end
         end
         `CHK(lows, (4 + p) * int'(rmrs_pkg::PULSE_CYC))
         evt(1'b1);
         host_u.send(4'h6, '0, '0, 1'b0, 1'b1);
         evt(1'b0);
         `CHK(scan_active, 1'b0)
      end
      k = errs;
      host_u.send(4'h4, 24'h010203, '0, 1'b0, 1'b0);
      host_u.send(4'h4, 24'h021600, '0, 1'b0, 1'b1);
      wt(4);
      `CHK(errs - k, 1)
      host_u.send(4'h5, '0, '0, 1'b0, 1'b1);
      wt(3);
      `CHK(scan_active, 1'b0)
      end_sim();
   end
endmodule
